// ### hw/cgr_control_regs.sv
// Control and configuration register bank of the video and audio clock generator
// What this block does
// - Writing one to soft reset returns every configuration register to default.
// - Soft reset is never stored, so it self-clears and reads zero.
// - Control bit 6 drives power-down and resets to zero.
// - Control bit 5 enables automatic format detection, default enabled.
// - Loop mode 00 free-run, 01 genlock (default), 10 holdover, 11 reserved.
// - Control bit 2 picks holdover (0) or free-run (1) on missing reference.
// - Forced high rate set: second loop 148.5 MHz, third 148.35 MHz.
// - Forced high rate clear: both loops use the format's native rate.
// - Global output enable clear floats all clock and frame outputs.
// - Auto polarity detects horizontal polarity and applies it to V and F.
// - Manual polarity takes each input's polarity from its override bit.
// - Override bits: zero active low, one active high, all default zero.
// - Applied polarity aligns output timing to leading H and V edges.
// - Second loop format field is bits 5:0, reset 001110, top reserved.
`timescale 1ns/10ps
`include "cgr_regs.svh"
module cgr_control_regs
    import cgr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h65,
    parameter int POL_CNT_W = 12,
    parameter logic [5:0] FMT3_RST = 6'h00
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic reference_missing,
    input wire logic second_loop_native_high,
    input wire logic third_loop_native_high,
    input wire logic [3:0] clock_output_active,
    input wire logic [3:0] frame_output_active,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic field_in,
    output logic power_down,
    output logic auto_format_detect_enable,
    output cgr_loop_e reference_loop_state,
    output logic second_loop_high_rate,
    output logic third_loop_high_rate,
    output logic [3:0] clock_output_oe,
    output logic [3:0] frame_output_oe,
    output logic [5:0] second_loop_format_field,
    output logic [5:0] third_loop_format_field,
    output logic hsync_detected_high,
    output logic h_lead,
    output logic v_lead,
    output logic field_active
);

    // ==========================================================
    // Serial bridge
    cgr_reg_if bus ();

    cgr_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bridge (
        .mclk(mclk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // Configuration registers
    logic [`CGR_CTRL_W-1:0] ctrl_q;
    logic [`CGR_POL_W-1:0] pol_q;
    logic [`CGR_FMT_W-1:0] fmt2_q;
    logic [`CGR_FMT_W-1:0] fmt3_q;

    wire wr_ctrl = bus.wr_stb & hit(bus.waddr, `CGR_ADDR_DEV_CTRL);
    wire wr_pol = bus.wr_stb & hit(bus.waddr, `CGR_ADDR_POLARITY);
    wire wr_fmt2 = bus.wr_stb & hit(bus.waddr, `CGR_ADDR_FMT2);
    wire wr_fmt3 = bus.wr_stb & hit(bus.waddr, `CGR_ADDR_FMT3);
    wire soft_rst = wr_ctrl & bus.wdata[`CGR_BIT_SOFT_RST];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= `CGR_CTRL_RST;
            pol_q <= `CGR_POL_RST;
            fmt2_q <= `CGR_FMT2_RST;
            fmt3_q <= FMT3_RST;
        end
        else if (soft_rst)
        begin
            // Soft reset takes the whole bank back; the rest of the write is dropped
            ctrl_q <= `CGR_CTRL_RST;
            pol_q <= `CGR_POL_RST;
            fmt2_q <= `CGR_FMT2_RST;
            fmt3_q <= FMT3_RST;
        end
        else
        begin
            // Bit 7 has no storage, so it clears itself
            if (wr_ctrl)
                ctrl_q <= bus.wdata[`CGR_CTRL_W-1:0];
            // Reserved upper bits are simply not stored
            if (wr_pol)
                pol_q <= bus.wdata[`CGR_POL_W-1:0];
            if (wr_fmt2)
                fmt2_q <= bus.wdata[`CGR_FMT_W-1:0];
            if (wr_fmt3)
                fmt3_q <= bus.wdata[`CGR_FMT_W-1:0];
        end
    end

    // ==========================================================
    // Read mux, reserved bits read as zero
    wire [7:0] rd_ctrl = {1'b0, ctrl_q};
    wire [7:0] rd_pol = {4'h0, pol_q};
    wire [7:0] rd_fmt2 = {2'h0, fmt2_q};
    wire [7:0] rd_fmt3 = {2'h0, fmt3_q};

    assign bus.rdata = hit(bus.raddr, `CGR_ADDR_DEV_CTRL) ? rd_ctrl :
                       hit(bus.raddr, `CGR_ADDR_POLARITY) ? rd_pol :
                       hit(bus.raddr, `CGR_ADDR_FMT2) ? rd_fmt2 :
                       hit(bus.raddr, `CGR_ADDR_FMT3) ? rd_fmt3 : 8'h00;

    // ==========================================================
    // Device control decode
    wire global_output_enable = ctrl_q[`CGR_BIT_GOE];
    wire force_hi = ctrl_q[`CGR_BIT_FORCE_HI];
    wire miss_free = ctrl_q[`CGR_BIT_MISS_ACT];
    wire [1:0] mode = ctrl_q[`CGR_BIT_MODE_HI:`CGR_BIT_MODE_LO];

    // Reserved mode 11 is stored as the host writes it; it is run as genlock
    wire cgr_loop_e miss_state = miss_free ? LOOP_FREE_RUN : LOOP_HOLDOVER;
    wire cgr_loop_e lock_state = reference_missing ? miss_state : LOOP_GENLOCK;
    wire cgr_loop_e loop_d = (mode == LOOP_FREE_RUN) ? LOOP_FREE_RUN :
                             (mode == LOOP_HOLDOVER) ? LOOP_HOLDOVER : lock_state;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_down <= 1'b0;
            auto_format_detect_enable <= 1'b1;
            reference_loop_state <= LOOP_GENLOCK;
            second_loop_high_rate <= 1'b1;
            third_loop_high_rate <= 1'b1;
            clock_output_oe <= 4'h0;
            frame_output_oe <= 4'h0;
        end
        else
        begin
            power_down <= ctrl_q[`CGR_BIT_PWR_DN];
            auto_format_detect_enable <= ctrl_q[`CGR_BIT_AFD_EN];
            reference_loop_state <= loop_d;
            second_loop_high_rate <= force_hi | second_loop_native_high;
            third_loop_high_rate <= force_hi | third_loop_native_high;
            clock_output_oe <= clock_output_active & {4{global_output_enable}};
            frame_output_oe <= frame_output_active & {4{global_output_enable}};
        end
    end

    assign second_loop_format_field = fmt2_q;
    assign third_loop_format_field = fmt3_q;

    // ==========================================================
    // Sync polarity
    // Majority vote of hsync level: the inactive level dominates the line,
    // so a mostly-low hsync is an active-high pulse
    logic [POL_CNT_W-1:0] pcnt_q;
    logic hpol_q;
    logic vpol_q;
    logic fpol_q;
    logic hn_q;
    logic vn_q;

    wire cnt_top = &pcnt_q;
    wire cnt_bot = ~|pcnt_q;
    wire det_high = ~pcnt_q[POL_CNT_W-1];
    wire autopol = pol_q[`CGR_BIT_AUTOPOL];
    wire hpol_d = autopol ? det_high : pol_q[`CGR_BIT_HPOL];
    wire vpol_d = autopol ? det_high : pol_q[`CGR_BIT_VPOL];
    wire fpol_d = autopol ? det_high : pol_q[`CGR_BIT_FPOL];
    wire h_n = hsync_in ^ ~hpol_q;
    wire v_n = vsync_in ^ ~vpol_q;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            pcnt_q <= {1'b1, {(POL_CNT_W-1){1'b0}}};
        else if (hsync_in && !cnt_top)
            pcnt_q <= pcnt_q + 1'b1;
        else if (!hsync_in && !cnt_bot)
            pcnt_q <= pcnt_q - 1'b1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hpol_q <= 1'b0;
            vpol_q <= 1'b0;
            fpol_q <= 1'b0;
            // Start as if sync were already asserted, so reset never fakes a leading edge;
            // a genuine edge in the first cycle after reset is missed
            hn_q <= 1'b1;
            vn_q <= 1'b1;
            h_lead <= 1'b0;
            v_lead <= 1'b0;
            field_active <= 1'b0;
        end
        else
        begin
            hpol_q <= hpol_d;
            vpol_q <= vpol_d;
            fpol_q <= fpol_d;
            hn_q <= h_n;
            vn_q <= v_n;
            h_lead <= h_n & ~hn_q;
            v_lead <= v_n & ~vn_q;
            field_active <= field_in ^ ~fpol_q;
        end
    end

    assign hsync_detected_high = det_high;

    // ==========================================================
    // Checks
    property p_soft_reset;
        @(posedge mclk) disable iff (!arst_n)
        soft_rst |=> (ctrl_q == `CGR_CTRL_RST) && (pol_q == `CGR_POL_RST)
                     && (fmt2_q == `CGR_FMT2_RST) && (fmt3_q == FMT3_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed defaults");

    property p_soft_reads_zero;
        @(posedge mclk) disable iff (!arst_n)
        hit(bus.raddr, `CGR_ADDR_DEV_CTRL) |-> !bus.rdata[`CGR_BIT_SOFT_RST];
    endproperty
    a_soft_reads_zero: assert property (p_soft_reads_zero) else $error("soft reset read one");

    property p_power_down;
        @(posedge mclk) disable iff (!arst_n)
        wr_ctrl && !soft_rst |=> ##1 power_down == $past(bus.wdata[`CGR_BIT_PWR_DN], 2);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down not applied");

    property p_afd;
        @(posedge mclk) disable iff (!arst_n)
        wr_ctrl && !soft_rst |=> ##1
            auto_format_detect_enable == $past(bus.wdata[`CGR_BIT_AFD_EN], 2);
    endproperty
    a_afd: assert property (p_afd) else $error("format detect enable wrong");

    property p_loop_forced;
        @(posedge mclk) disable iff (!arst_n)
        (mode == LOOP_FREE_RUN) || (mode == LOOP_HOLDOVER) |=> reference_loop_state == $past(mode);
    endproperty
    a_loop_forced: assert property (p_loop_forced) else $error("forced loop mode ignored");

    property p_missing_action;
        @(posedge mclk) disable iff (!arst_n)
        (mode == LOOP_GENLOCK) && reference_missing |=>
            reference_loop_state == ($past(miss_free) ? LOOP_FREE_RUN : LOOP_HOLDOVER);
    endproperty
    a_missing_action: assert property (p_missing_action) else $error("wrong missing action");

    property p_force_rate;
        @(posedge mclk) disable iff (!arst_n)
        force_hi |=> second_loop_high_rate && third_loop_high_rate;
    endproperty
    a_force_rate: assert property (p_force_rate) else $error("high rate not forced");

    property p_native_rate;
        @(posedge mclk) disable iff (!arst_n)
        !force_hi |=> (second_loop_high_rate == $past(second_loop_native_high))
                      && (third_loop_high_rate == $past(third_loop_native_high));
    endproperty
    a_native_rate: assert property (p_native_rate) else $error("native rate not used");

    property p_goe;
        @(posedge mclk) disable iff (!arst_n)
        !global_output_enable |=> (clock_output_oe == 4'h0) && (frame_output_oe == 4'h0);
    endproperty
    a_goe: assert property (p_goe) else $error("outputs drive while disabled");

    property p_auto_pol;
        @(posedge mclk) disable iff (!arst_n)
        autopol |=> (hpol_q == $past(det_high)) && (vpol_q == hpol_q) && (fpol_q == hpol_q);
    endproperty
    a_auto_pol: assert property (p_auto_pol) else $error("auto polarity not shared");

    property p_manual_pol;
        @(posedge mclk) disable iff (!arst_n)
        !autopol |=> ({hpol_q, vpol_q, fpol_q} == $past(pol_q[`CGR_BIT_HPOL:`CGR_BIT_FPOL]));
    endproperty
    a_manual_pol: assert property (p_manual_pol) else $error("override polarity ignored");

    property p_lead_edge;
        @(posedge mclk) disable iff (!arst_n)
        h_lead |-> $past(h_n) && !$past(hn_q);
    endproperty
    a_lead_edge: assert property (p_lead_edge) else $error("h lead not on leading edge");

    property p_fmt2_write;
        @(posedge mclk) disable iff (!arst_n)
        wr_fmt2 |=> second_loop_format_field == $past(bus.wdata[`CGR_FMT_W-1:0]);
    endproperty
    a_fmt2_write: assert property (p_fmt2_write) else $error("format field not written");

endmodule

// ### hw/cgr_i2c_slave.sv
// Two-wire serial management slave with register pointer and auto increment
`timescale 1ns/10ps
`include "cgr_regs.svh"
module cgr_i2c_slave
    import cgr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h65
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    cgr_reg_if.bridge bus
);

    logic scl_q;
    logic sda_q;
    logic nack_q;
    logic rw_q;
    logic wr_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic [7:0] waddr_q;
    logic [7:0] wdata_q;
    cgr_i2c_e st_q;
    cgr_phase_e ph_q;

    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    // Start and stop are sda edges while scl stays high
    wire start_c = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_done = scl_fall && (bit_q == `CGR_I2C_BYTE_BITS);
    wire addr_hit = (sh_q[7:1] == DEV_ADDR);

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = (st_q == I2C_ACK) | ((st_q == I2C_TX) & ~sh_q[7]);
    assign bus.wr_stb = wr_q;
    assign bus.waddr = waddr_q;
    assign bus.wdata = wdata_q;
    assign bus.raddr = ptr_q;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= I2C_IDLE;
            ph_q <= PH_ADDR;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
        end
        else
        begin
            wr_q <= 1'b0;
            if (stop_c)
                st_q <= I2C_IDLE;
            else if (start_c)
            begin
                st_q <= I2C_RX;
                ph_q <= PH_ADDR;
                bit_q <= 4'h0;
            end
            else
            begin
                case (st_q)
                    I2C_RX:
                        if (scl_rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_in};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (byte_done)
                        begin
                            bit_q <= 4'h0;
                            st_q <= I2C_ACK;
                            if (ph_q == PH_ADDR)
                            begin
                                rw_q <= sh_q[0];
                                ph_q <= PH_PTR;
                                if (!addr_hit)
                                    st_q <= I2C_IDLE;
                            end
                            else if (ph_q == PH_PTR)
                            begin
                                ptr_q <= sh_q;
                                ph_q <= PH_DATA;
                            end
                            else
                            begin
                                wr_q <= 1'b1;
                                waddr_q <= ptr_q;
                                wdata_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    I2C_ACK:
                        if (scl_fall)
                        begin
                            st_q <= rw_q ? I2C_TX : I2C_RX;
                            if (rw_q)
                                sh_q <= bus.rdata;
                        end
                    I2C_TX:
                        if (scl_fall)
                        begin
                            sh_q <= {sh_q[6:0], 1'b1};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == `CGR_I2C_LAST_TX_BIT)
                            begin
                                st_q <= I2C_RACK;
                                bit_q <= 4'h0;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    I2C_RACK:
                        if (scl_rise)
                            nack_q <= sda_in;
                        else if (scl_fall)
                        begin
                            st_q <= nack_q ? I2C_IDLE : I2C_TX;
                            sh_q <= bus.rdata;
                        end
                    default:
                        st_q <= I2C_IDLE;
                endcase
            end
        end
    end

endmodule

// ### hw/cgr_pkg.sv
// Types shared by the clock generator control bank and its serial bridge
package cgr_pkg;

    typedef enum logic [1:0] {
        LOOP_FREE_RUN = 2'b00,
        LOOP_GENLOCK = 2'b01,
        LOOP_HOLDOVER = 2'b10,
        LOOP_RESERVED = 2'b11
    } cgr_loop_e;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_RX = 3'b001,
        I2C_ACK = 3'b010,
        I2C_TX = 3'b011,
        I2C_RACK = 3'b100
    } cgr_i2c_e;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_PTR = 2'b01,
        PH_DATA = 2'b10
    } cgr_phase_e;

endpackage

// ### hw/cgr_reg_if.sv
// Register access carrier between the serial bridge and the register bank
`timescale 1ns/10ps
interface cgr_reg_if;
    logic wr_stb;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport bridge (output wr_stb, output waddr, output wdata, output raddr, input rdata);
    modport bank (input wr_stb, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### hw/cgr_regs.svh
// Register offsets, field positions and reset values of the clock generator control bank
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH

`define CGR_ADDR_DEV_CTRL 8'h05
`define CGR_ADDR_POLARITY 8'h06
`define CGR_ADDR_FMT2 8'h07
`define CGR_ADDR_FMT3 8'h08

`define CGR_BIT_SOFT_RST 7
`define CGR_BIT_PWR_DN 6
`define CGR_BIT_AFD_EN 5
`define CGR_BIT_MODE_HI 4
`define CGR_BIT_MODE_LO 3
`define CGR_BIT_MISS_ACT 2
`define CGR_BIT_FORCE_HI 1
`define CGR_BIT_GOE 0

`define CGR_BIT_AUTOPOL 3
`define CGR_BIT_HPOL 2
`define CGR_BIT_VPOL 1
`define CGR_BIT_FPOL 0

`define CGR_CTRL_W 7
`define CGR_POL_W 4
`define CGR_FMT_W 6

`define CGR_CTRL_RST 7'h2B
`define CGR_POL_RST 4'h8
`define CGR_FMT2_RST 6'h0E

`define CGR_I2C_BYTE_BITS 4'h8
`define CGR_I2C_LAST_TX_BIT 4'h7

`endif

// ### tb/cgr_control_regs_tb_top.sv
// Self-checking bench for the clock generator control register bank
`timescale 1ns/10ps
module cgr_control_regs_tb_top;
    import cgr_pkg::*;
    localparam logic [6:0] DEV = 7'h65;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic ref_miss = 1'b0;
    logic nat2 = 1'b0;
    logic nat3 = 1'b0;
    logic [3:0] clk_act = 4'hA;
    logic [3:0] frm_act = 4'h5;
    logic hs = 1'b0;
    logic vs = 1'b0;
    logic fld = 1'b0;
    logic sda_out, sda_oe, pwr, afd, hr2, hr3, hs_hi, h_lead, v_lead, fld_act;
    cgr_loop_e loop_st;
    logic [3:0] clk_oe, frm_oe;
    logic [5:0] fmt2, fmt3;
    logic [7:0] rd;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int h_cnt = 0;
    int v_cnt = 0;
    // Open-drain wire with pull-up: low if either party pulls
    wire sda_w = sda_m & ~(sda_oe & ~sda_out);

    cgr_control_regs #(.DEV_ADDR(DEV), .POL_CNT_W(4)) cgr_control_regs_inst (
        .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .reference_missing(ref_miss),
        .second_loop_native_high(nat2), .third_loop_native_high(nat3),
        .clock_output_active(clk_act), .frame_output_active(frm_act),
        .hsync_in(hs), .vsync_in(vs), .field_in(fld), .power_down(pwr),
        .auto_format_detect_enable(afd), .reference_loop_state(loop_st),
        .second_loop_high_rate(hr2), .third_loop_high_rate(hr3),
        .clock_output_oe(clk_oe), .frame_output_oe(frm_oe),
        .second_loop_format_field(fmt2), .third_loop_format_field(fmt3),
        .hsync_detected_high(hs_hi), .h_lead(h_lead), .v_lead(v_lead),
        .field_active(fld_act)
    );

    // ==========================================================
    // Clock, pulse counters and hang guard
    initial
    begin
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (h_lead === 1'b1)
            h_cnt <= h_cnt + 1;
        if (v_lead === 1'b1)
            v_cnt <= v_cnt + 1;
        if (cycles == 40000)
        begin
            err_total = err_total + 1;
            wrap_up();
        end
    end

    // ==========================================================
    // Serial access tasks
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Wire sampled on a falling mclk edge, away from the design's updates
    task automatic bitc(input logic b, output logic r);
        sda_m <= b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        @(negedge mclk);
        r = sda_w;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic wbyte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitc(d[i], a);
        bitc(1'b1, a);
        chk({7'h00, a}, 8'h00);
    endtask

    task automatic start();
        sda_m <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic stop();
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(8);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        start();
        wbyte({DEV, 1'b0});
        wbyte(a);
        wbyte(d);
        stop();
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic n;
        start();
        wbyte({DEV, 1'b0});
        wbyte(a);
        start();
        wbyte({DEV, 1'b1});
        for (int i = 7; i >= 0; i--)
            bitc(1'b1, rd[i]);
        bitc(1'b1, n);
        stop();
        chk(rd, exp);
    endtask

    // Field level after rise, then lead pulses seen on rise and over a whole pulse
    task automatic pol_chk(input logic [7:0] pol, input logic [7:0] exp);
        int h0;
        int v0;
        reg_wr(8'h06, pol);
        h0 = h_cnt;
        v0 = v_cnt;
        fld <= 1'b1;
        hs <= 1'b1;
        vs <= 1'b1;
        tick(4);
        chk({5'h00, fld_act, 1'(h_cnt - h0), 1'(v_cnt - v0)}, exp);
        hs <= 1'b0;
        vs <= 1'b0;
        tick(4);
        chk(8'(h_cnt - h0) + 8'(v_cnt - v0), 8'h02);
    endtask

    // ==========================================================
    // Test sequence
    initial
    begin
        tick(8);
        arst_n <= 1'b1;
        tick(4);
        chk(8'(h_cnt + v_cnt), 8'h00);
        chk({clk_oe, frm_oe}, 8'hA5);
        chk({pwr, afd, loop_st, hr2, hr3, 2'b00}, 8'h5C);
        chk({2'b00, fmt2}, 8'h0E);
        rchk(8'h05, 8'h2B);
        rchk(8'h06, 8'h08);
        rchk(8'h07, 8'h0E);
        rchk(8'h04, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(8'h05, {3'b001, m[1:0], 3'b011});
            rchk(8'h05, {3'b001, m[1:0], 3'b011});
            chk({6'h00, loop_st}, (m == 3) ? 8'h01 : 8'(m));
        end
        ref_miss <= 1'b1;
        reg_wr(8'h05, 8'h2B);
        chk({6'h00, loop_st}, 8'h02);
        reg_wr(8'h05, 8'h2F);
        chk({6'h00, loop_st}, 8'h00);
        ref_miss <= 1'b0;
        nat2 <= 1'b1;
        reg_wr(8'h05, 8'h29);
        chk({6'h00, hr2, hr3}, 8'h02);
        nat2 <= 1'b0;
        nat3 <= 1'b1;
        tick(4);
        chk({6'h00, hr2, hr3}, 8'h01);
        reg_wr(8'h05, 8'h2A);
        chk({clk_oe, frm_oe}, 8'h00);
        chk({6'h00, hr2, hr3}, 8'h03);
        reg_wr(8'h05, 8'h4B);
        chk({6'h00, pwr, afd}, 8'h02);
        rchk(8'h05, 8'h4B);
        reg_wr(8'h07, 8'h2A);
        rchk(8'h07, 8'h2A);
        chk({2'b00, fmt2}, 8'h2A);
        reg_wr(8'h08, 8'h15);
        rchk(8'h08, 8'h15);
        chk({2'b00, fmt3}, 8'h15);
        pol_chk(8'h07, 8'h07);
        pol_chk(8'h04, 8'h02);
        pol_chk(8'h00, 8'h00);
        chk({7'h00, hs_hi}, 8'h01);
        pol_chk(8'h08, 8'h07);
        hs <= 1'b1;
        tick(60);
        chk({6'h00, hs_hi, fld_act}, 8'h00);
        hs <= 1'b0;
        tick(60);
        reg_wr(8'h06, 8'h07);
        reg_wr(8'h05, 8'h80);
        rchk(8'h05, 8'h2B);
        rchk(8'h06, 8'h08);
        rchk(8'h07, 8'h0E);
        rchk(8'h08, 8'h00);
        chk({2'b00, fmt3}, 8'h00);
        chk({pwr, afd, loop_st, hr2, hr3, 2'b00}, 8'h5C);
        chk({clk_oe, frm_oe}, 8'hA5);
        wrap_up();
    end
endmodule
